// File: rtl/mad_pkg.sv
// constants for the memory address decoder
package mad_pkg;
    // ======================================================
    // widths and counts
    localparam int ADDR_W = 16;
    localparam int EA_W = 13;
    localparam int DATA_W = 8;
    localparam int NUM_PKG = 4;
    localparam int NUM_HALF = 8;
    localparam int NUM_ROM = 6;
    localparam int SYNC_W = 29;

    // ======================================================
    // address map
    localparam logic [12:0] RAM_TOP = 13'h03ff;
    localparam logic [2:0] REGION_LOW = 3'h0;
    localparam logic [2:0] ROM_FIRST_BLK = 3'h2;
    localparam logic [1:0] GROUP_BLK = 2'h0;
    localparam logic [3:0][12:0] PKG_BASE = {13'h0428, 13'h0418, 13'h0414, 13'h040c};

    // ======================================================
    // adapter register addresses
    localparam logic [15:0] GP_PORT_A_CONTROL = 16'h040c;
    localparam logic [15:0] GP_PORT_A_DATA_DIR = 16'h040d;
    localparam logic [15:0] GP_PORT_B_CONTROL = 16'h040e;
    localparam logic [15:0] GP_PORT_B_DATA_DIR = 16'h040f;
    localparam logic [15:0] TAPE_READ_CONTROL = 16'h0414;
    localparam logic [15:0] TAPE_READ_DATA_DIR = 16'h0415;
    localparam logic [15:0] TAPE_WRITE_CONTROL = 16'h0416;
    localparam logic [15:0] TAPE_WRITE_DATA_DIR = 16'h0417;
    localparam logic [15:0] TAPE_AUX_A_CONTROL = 16'h0418;
    localparam logic [15:0] TAPE_AUX_A_DATA_DIR = 16'h0419;
    localparam logic [15:0] TAPE_AUX_B_CONTROL = 16'h041a;
    localparam logic [15:0] TAPE_AUX_B_DATA_DIR = 16'h041b;
    localparam logic [15:0] KEYPAD_CONTROL = 16'h0428;
    localparam logic [15:0] KEYPAD_DATA_DIR = 16'h0429;
    localparam logic [15:0] BUS_ADDR_SWITCH_CONTROL = 16'h042a;
    localparam logic [15:0] BUS_ADDR_SWITCH_DATA_DIR = 16'h042b;

    // ======================================================
    // control register fields
    localparam int CTL_S1_IRQ_EN = 0;
    localparam int CTL_S1_RISE = 1;
    localparam int CTL_PERIPH_SEL = 2;
    localparam int CTL_S2_IRQ_EN = 3;
    localparam int CTL_S2_RISE = 4;
    localparam int CTL_S2_OUT = 5;
    localparam int CTL_W = 6;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] UNUSED_DATA = 8'h00;
endpackage : mad_pkg

// File: rtl/mad_half_if.sv
// bus between the decoder and one adapter half
`timescale 1ns/1ps
`default_nettype none
interface mad_half_if;
    logic sel;
    logic wr;
    logic rd;
    logic odd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport dec (output sel, output wr, output rd, output odd, output wdata, input rdata);
    modport half (input sel, input wr, input rd, input odd, input wdata, output rdata);
endinterface : mad_half_if
`default_nettype wire

// File: rtl/mad_half.sv
// one adapter half: control, direction and peripheral registers
`timescale 1ns/1ps
`default_nettype none
module mad_half (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    mad_half_if.half bus,
    input wire logic strobe1_i,
    input wire logic strobe2_i,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic strobe2_o,
    output logic strobe2_oe_o,
    output logic irq_n_o
);
    logic [5:0] ctl;
    logic [7:0] dir;
    logic [7:0] port_q;
    logic flag1;
    logic flag2;
    logic s1_d;
    logic s2_d;
    logic edge1;
    logic edge2;
    logic flag_clr;

    // ======================================================
    // strobe edges
    assign edge1 = ctl[mad_pkg::CTL_S1_RISE] ? (strobe1_i & ~s1_d) : (~strobe1_i & s1_d);
    assign edge2 = ~ctl[mad_pkg::CTL_S2_OUT]
        & (ctl[mad_pkg::CTL_S2_RISE] ? (strobe2_i & ~s2_d) : (~strobe2_i & s2_d));
    assign flag_clr = bus.sel & bus.rd & bus.odd & ctl[mad_pkg::CTL_PERIPH_SEL];

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1_d <= 1'b0;
            s2_d <= 1'b0;
        end else begin
            s1_d <= strobe1_i;
            s2_d <= strobe2_i;
        end
    end

    // ======================================================
    // flags, set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flag1 <= 1'b0;
            flag2 <= 1'b0;
        end else begin
            flag1 <= edge1 | (flag1 & ~flag_clr);
            flag2 <= edge2 | (flag2 & ~flag_clr);
        end
    end

    // ======================================================
    // register writes
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctl <= mad_pkg::CTL_RESET;
            dir <= mad_pkg::DIR_RESET;
            port_q <= mad_pkg::PORT_RESET;
        end else if (bus.sel && bus.wr) begin
            if (!bus.odd) begin
                ctl <= bus.wdata[5:0];
            end else if (ctl[mad_pkg::CTL_PERIPH_SEL]) begin
                port_q <= bus.wdata;
            end else begin
                dir <= bus.wdata;
            end
        end
    end

    // ======================================================
    // read mux
    always_comb begin
        if (!bus.odd) begin
            bus.rdata = {flag1, flag2, ctl};
        end else if (ctl[mad_pkg::CTL_PERIPH_SEL]) begin
            bus.rdata = (dir & port_q) | (~dir & pin_i);
        end else begin
            bus.rdata = dir;
        end
    end

    // ======================================================
    // pins and interrupt
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_o <= mad_pkg::PORT_RESET;
            pin_oe_o <= mad_pkg::DIR_RESET;
            strobe2_o <= 1'b0;
            strobe2_oe_o <= 1'b0;
            irq_n_o <= 1'b1;
        end else begin
            pin_o <= port_q;
            pin_oe_o <= dir;
            strobe2_o <= ctl[mad_pkg::CTL_S2_IRQ_EN];
            strobe2_oe_o <= ctl[mad_pkg::CTL_S2_OUT];
            irq_n_o <= ~((flag1 & ctl[mad_pkg::CTL_S1_IRQ_EN])
                | (flag2 & ctl[mad_pkg::CTL_S2_IRQ_EN] & ~ctl[mad_pkg::CTL_S2_OUT]));
        end
    end
endmodule : mad_half
`default_nettype wire

// File: rtl/mad_decoder.sv
// memory address decoder with its four adapter packages
// Function
// - selects come from address bits eight to thirteen; package selects also use bits two to seven
// - decoding only while valid address or bus-available
// - first stage picks ROMs and enables second
// - second stage: adapter group, clock-qualified third stage
// - RAMs enabled only while phase two high
// - address bits fourteen and fifteen ignored; bit thirteen used only by 2K ROM decode
// - RAM pair answers the lowest 1K
// - each adapter package owns four addresses
// - 1K ROMs in six consecutive 1K blocks
// - 2K ROMs in six consecutive 2K blocks
// - both nibble RAMs selected together
// - test input high overrides top ROM enable
// - fixture enable is phase two and valid
// - adapter selected: two selects high, one low
// - address bits zero, one pick register and half
// - control even, peripheral/direction odd by control bit
// - direction bit one drives pin, zero reads
// - strobe input edge pulls half interrupt low
`timescale 1ns/1ps
`default_nettype none
module mad_decoder (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic valid_address_flag_i,
    input wire logic bus_available_i,
    input wire logic read_not_write_i,
    input wire logic phase_two_clock_i,
    input wire logic [7:0] wdata_i,
    input wire logic rom_2k_i,
    input wire logic test_override_i,
    input wire logic [7:0] half_strobe_input_i,
    input wire logic [7:0] half_strobe_second_i,
    input wire logic [7:0][7:0] port_pin_i,
    output logic [5:0] rom_sel_o,
    output logic ram_sel_low_o,
    output logic ram_sel_high_o,
    output logic adapter_group_select_o,
    output logic fixture_enable_o,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic [7:0][7:0] port_pin_o,
    output logic [7:0][7:0] port_pin_oe_o,
    output logic [7:0] half_strobe_second_o,
    output logic [7:0] half_strobe_second_oe_o,
    output logic [7:0] half_interrupt_out_n_o
);
    // ======================================================
    // input synchronisers
    logic [28:0] sync_a;
    logic [28:0] sync_b;
    logic [15:0] strb_a;
    logic [15:0] strb_b;
    logic [63:0] pin_a;
    logic [63:0] pin_b;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {addr_i, valid_address_flag_i, bus_available_i, read_not_write_i,
                phase_two_clock_i, wdata_i, test_override_i};
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            strb_a <= '0;
            strb_b <= '0;
            pin_a <= '0;
            pin_b <= '0;
        end else begin
            strb_a <= {half_strobe_second_i, half_strobe_input_i};
            strb_b <= strb_a;
            pin_a <= port_pin_i;
            pin_b <= pin_a;
        end
    end

    logic [15:0] addr_s;
    logic vma_s;
    logic ba_s;
    logic rnw_s;
    logic p2_s;
    logic [7:0] wdata_s;
    logic tover_s;

    assign addr_s = sync_b[28:13];
    assign vma_s = sync_b[12];
    assign ba_s = sync_b[11];
    assign rnw_s = sync_b[10];
    assign p2_s = sync_b[9];
    assign wdata_s = sync_b[8:1];
    assign tover_s = sync_b[0];

    // ======================================================
    // fitted rom size strap, caught after reset
    logic rom_2k;
    logic strap_taken;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rom_2k <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            rom_2k <= rom_2k_i;
            strap_taken <= 1'b1;
        end
    end

    // ======================================================
    // three-stage decode
    logic [12:0] ea;
    logic stage1_en;
    logic stage2_en;
    logic stage3_en;
    logic group_sel;
    logic [2:0] rom_blk;
    logic [5:0] next_rom_sel;
    logic next_ram;
    logic [3:0] pkg_sel;
    logic pkg_any;
    logic [2:0] half_idx;

    assign ea = addr_s[12:0];
    assign stage1_en = vma_s | ba_s;
    assign stage2_en = stage1_en && (ea[12:11] == mad_pkg::REGION_LOW[1:0]);
    assign stage3_en = stage2_en && !ea[10] && p2_s;
    assign group_sel = stage2_en && ea[10] && (ea[9:8] == mad_pkg::GROUP_BLK);
    assign rom_blk = rom_2k ? addr_s[13:11] : ea[12:10];
    assign next_ram = stage3_en && (ea <= mad_pkg::RAM_TOP);

    always_comb begin
        next_rom_sel = '0;
        if (stage1_en && rom_blk >= mad_pkg::ROM_FIRST_BLK) begin
            next_rom_sel[3'(rom_blk - mad_pkg::ROM_FIRST_BLK)] = 1'b1;
        end
        if (tover_s) begin
            next_rom_sel[mad_pkg::NUM_ROM - 1] = 1'b0;
        end
    end

    // adapter chip selects: group high, block match high, upper bit low
    genvar gp;
    generate
        for (gp = 0; gp < mad_pkg::NUM_PKG; gp++) begin : g_pkg
            logic cs_high_first;
            logic cs_high_second;
            logic cs_low;
            assign cs_high_first = group_sel;
            assign cs_high_second = (ea[7:2] == mad_pkg::PKG_BASE[gp][7:2]);
            assign cs_low = ea[11];
            assign pkg_sel[gp] = cs_high_first & cs_high_second & ~cs_low;
        end
    endgenerate

    assign pkg_any = |pkg_sel;

    always_comb begin
        half_idx = 3'h0;
        for (int k = 0; k < mad_pkg::NUM_PKG; k++) begin
            if (pkg_sel[k]) begin
                half_idx = {2'(k), ea[1]};
            end
        end
    end

    // ======================================================
    // bus cycle timing
    logic p2_d;
    logic cycle_end;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            p2_d <= 1'b0;
        end else begin
            p2_d <= p2_s;
        end
    end

    assign cycle_end = p2_d & ~p2_s;

    // ======================================================
    // adapter halves
    logic [7:0][7:0] half_rdata;
    mad_half_if hif[mad_pkg::NUM_HALF] ();

    genvar gh;
    generate
        for (gh = 0; gh < mad_pkg::NUM_HALF; gh++) begin : g_half
            assign hif[gh].sel = pkg_any && (half_idx == 3'(gh));
            assign hif[gh].wr = cycle_end && stage1_en && !rnw_s;
            assign hif[gh].rd = cycle_end && stage1_en && rnw_s;
            assign hif[gh].odd = ea[0];
            assign hif[gh].wdata = wdata_s;
            assign half_rdata[gh] = hif[gh].rdata;

            mad_half u_half (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .bus(hif[gh]),
                .strobe1_i(strb_b[gh]),
                .strobe2_i(strb_b[gh + 8]),
                .pin_i(pin_b[gh * 8 +: 8]),
                .pin_o(port_pin_o[gh]),
                .pin_oe_o(port_pin_oe_o[gh]),
                .strobe2_o(half_strobe_second_o[gh]),
                .strobe2_oe_o(half_strobe_second_oe_o[gh]),
                .irq_n_o(half_interrupt_out_n_o[gh])
            );
        end
    endgenerate

    // ======================================================
    // registered selects
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rom_sel_o <= '0;
            ram_sel_low_o <= 1'b0;
            ram_sel_high_o <= 1'b0;
            adapter_group_select_o <= 1'b0;
            fixture_enable_o <= 1'b0;
        end else begin
            rom_sel_o <= next_rom_sel;
            ram_sel_low_o <= next_ram;
            ram_sel_high_o <= next_ram;
            adapter_group_select_o <= group_sel;
            fixture_enable_o <= p2_s & vma_s;
        end
    end

    // ======================================================
    // read data from adapters
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_o <= mad_pkg::UNUSED_DATA;
            rdata_valid_o <= 1'b0;
        end else if (pkg_any && rnw_s && p2_s) begin
            rdata_o <= half_rdata[half_idx];
            rdata_valid_o <= 1'b1;
        end else begin
            rdata_o <= mad_pkg::UNUSED_DATA;
            rdata_valid_o <= 1'b0;
        end
    end
endmodule : mad_decoder
`default_nettype wire

// File: sim/mad_decoder_checker.sv
// concurrent checks on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic valid_address_flag_i,
    input wire logic bus_available_i,
    input wire logic read_not_write_i,
    input wire logic phase_two_clock_i,
    input wire logic test_override_i,
    input wire logic [5:0] rom_sel_o,
    input wire logic ram_sel_low_o,
    input wire logic ram_sel_high_o,
    input wire logic adapter_group_select_o,
    input wire logic fixture_enable_o,
    input wire logic [7:0] rdata_o,
    input wire logic rdata_valid_o
);
    // ======================================================
    // settle counter after reset release
    logic [1:0] up_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    wire logic ready = (up_cnt == 2'h3);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // ======================================================
    // decode relations, three edges of input latency
    sequence s_bus_on;
        $past(valid_address_flag_i, 3) || $past(bus_available_i, 3);
    endsequence
    sequence s_adapter_read;
        $past(phase_two_clock_i, 3) && $past(read_not_write_i, 3) && adapter_group_select_o;
    endsequence

    AST_IDLE_NO_SEL: assert property (ready && !($past(valid_address_flag_i, 3) || $past(bus_available_i, 3))
        |-> rom_sel_o == 6'h00 && !ram_sel_low_o && !adapter_group_select_o) else $error("select without bus cycle");
    AST_RAM_WINDOW: assert property (ready ##0 s_bus_on ##0 ($past(addr_i[13:0], 3) <= 14'h03ff
        && $past(phase_two_clock_i, 3)) |-> ram_sel_low_o) else $error("ram not selected in low block");
    AST_RAM_PHASE: assert property (ram_sel_low_o |-> $past(phase_two_clock_i, 3))
        else $error("ram selected outside phase two");
    AST_RAM_PAIR: assert property (ram_sel_low_o == ram_sel_high_o) else $error("nibble rams differ");
    AST_ROM_ONEHOT: assert property (ready |-> $onehot0(rom_sel_o)) else $error("several roms selected");
    AST_TOP_ROM_OVR: assert property ($past(test_override_i, 3) |-> !rom_sel_o[5])
        else $error("top rom not overridden");
    AST_FIXTURE: assert property (ready |-> fixture_enable_o ==
        ($past(phase_two_clock_i, 3) && $past(valid_address_flag_i, 3))) else $error("fixture enable wrong");
    AST_GROUP: assert property (ready ##0 s_bus_on ##0 ($past(addr_i[13:8], 3) == 6'h04)
        |-> adapter_group_select_o) else $error("adapter group not selected");
    AST_READ_CYCLE: assert property (rdata_valid_o |-> s_adapter_read)
        else $error("read data valid outside adapter read");
    AST_RDATA_IDLE: assert property (ready && !rdata_valid_o |-> rdata_o == 8'h00)
        else $error("read data not zero when idle");
endmodule : mad_decoder_checker

bind mad_decoder mad_decoder_checker chk_u (.*);
`default_nettype wire

// File: sim/mad_cpu_model.sv
// processor bus model: address, control strobes and write data
`timescale 1ns/1ps
`default_nettype none
module mad_cpu_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    output logic [15:0] addr_o,
    output logic valid_o,
    output logic ba_o,
    output logic rnw_o,
    output logic p2_o,
    output logic [7:0] wdata_o
);
    initial begin
        addr_o = 16'h0000;
        valid_o = 1'b0;
        ba_o = 1'b0;
        rnw_o = 1'b1;
        p2_o = 1'b0;
        wdata_o = 8'h00;
    end

    // holds a static bus state long enough for selects to settle
    task automatic hold(input logic [15:0] a, input logic v, input logic b, input logic p);
        @(negedge clk_sys_i);
        addr_o <= a;
        valid_o <= v;
        ba_o <= b;
        p2_o <= p;
        rnw_o <= 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask : hold

    // one full access: phase two high four cycles, low four cycles
    task automatic access(input logic [15:0] a, input logic rd_wr_n, input logic [7:0] wd, output logic [7:0] rd);
        @(negedge clk_sys_i);
        addr_o <= a;
        valid_o <= 1'b1;
        ba_o <= 1'b0;
        rnw_o <= rd_wr_n;
        p2_o <= 1'b0;
        wdata_o <= rd_wr_n ? ~wd : wd;
        repeat (2) @(negedge clk_sys_i);
        p2_o <= 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rd = rdata_i;
        p2_o <= 1'b0;
        repeat (4) @(negedge clk_sys_i);
        valid_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~wd;
    endtask : access
endmodule : mad_cpu_model
`default_nettype wire

// File: sim/mad_decoder_tb.sv
// self-checking bench for the memory address decoder
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rom_2k = 1'b0;
    logic tovr = 1'b0;
    logic [7:0] stb1 = 8'h00;
    logic [7:0] stb2 = 8'h00;
    logic [7:0][7:0] pin_in = 64'h3c5a_96e1_0ff0_c3a5;
    logic [15:0] addr;
    logic valid_address_flag, ba, rnw, p2, ram_lo, ram_hi, grp, fix, rvld;
    logic [7:0] wdata, rdata, rd, s2o, s2oe, irq_n;
    logic [5:0] rom_sel;
    logic [7:0][7:0] pin_out, pin_oe;
    logic [7:0] dir_tab [8] = '{8'h0f, 8'hf0, 8'h00, 8'hff, 8'h5a, 8'ha5, 8'h33, 8'hcc};
    int errors = 0;
    int total_checks = 0;

    initial forever #25 clk = ~clk;

    mad_decoder dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .addr_i(addr), .valid_address_flag_i(valid_address_flag),
        .bus_available_i(ba), .read_not_write_i(rnw), .phase_two_clock_i(p2), .wdata_i(wdata),
        .rom_2k_i(rom_2k), .test_override_i(tovr), .half_strobe_input_i(stb1), .half_strobe_second_i(stb2),
        .port_pin_i(pin_in), .rom_sel_o(rom_sel), .ram_sel_low_o(ram_lo), .ram_sel_high_o(ram_hi),
        .adapter_group_select_o(grp), .fixture_enable_o(fix), .rdata_o(rdata), .rdata_valid_o(rvld),
        .port_pin_o(pin_out), .port_pin_oe_o(pin_oe), .half_strobe_second_o(s2o),
        .half_strobe_second_oe_o(s2oe), .half_interrupt_out_n_o(irq_n));
    mad_cpu_model cpu_u (.clk_sys_i(clk), .rdata_i(rdata), .addr_o(addr), .valid_o(valid_address_flag), .ba_o(ba),
        .rnw_o(rnw), .p2_o(p2), .wdata_o(wdata));

    // ======================================================
    // compare and report
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // ======================================================
    // scenarios
    task automatic do_reset(input logic mode);
        @(negedge clk);
        rst_n <= 1'b0;
        rom_2k <= mode;
        repeat (4) @(negedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        check({rom_sel, ram_lo, grp, fix, rvld, s2oe}, 64'h0);
        check(pin_oe, 64'h0);
        check(irq_n, 8'hff);
    endtask : do_reset

    task automatic t_ram();
        cpu_u.hold(16'h03ff, 1'b1, 1'b0, 1'b1);
        check({ram_lo, ram_hi, fix}, 3'b111);
        cpu_u.hold(16'h03ff, 1'b1, 1'b0, 1'b0);
        check({ram_lo, ram_hi, fix}, 3'b000);
        cpu_u.hold(16'h0400, 1'b1, 1'b0, 1'b1);
        check({ram_lo, grp}, 2'b01);
        cpu_u.hold(16'h2000, 1'b0, 1'b1, 1'b1);
        check({ram_lo, fix}, 2'b10);
        cpu_u.hold(16'h0000, 1'b0, 1'b0, 1'b1);
        check({rom_sel, ram_lo, grp}, 8'h00);
        cpu_u.access(16'h042c, 1'b1, 8'h00, rd);
        check(rd, 8'h00);
        cpu_u.access(16'h0410, 1'b1, 8'h00, rd);
        check(rd, 8'h00);
    endtask : t_ram

    task automatic t_rom_map(input logic mode);
        logic [15:0] a;
        for (int i = 0; i < 6; i++) begin
            a = mode ? 16'h1000 + 16'(i) * 16'h0800 : 16'h0800 + 16'(i) * 16'h0400;
            cpu_u.hold(a, 1'b1, 1'b0, 1'b1);
            check(rom_sel, 6'h01 << i);
            cpu_u.hold(a | (mode ? 16'hc000 : 16'he000), 1'b1, 1'b0, 1'b1);
            check(rom_sel, 6'h01 << i);
        end
        tovr <= 1'b1;
        cpu_u.hold(a, 1'b1, 1'b0, 1'b1);
        check(rom_sel, 6'h00);
        tovr <= 1'b0;
    endtask : t_rom_map

    task automatic t_ports();
        logic [15:0] b;
        for (int i = 0; i < 8; i++) begin
            b = {3'h0, mad_pkg::PKG_BASE[i / 2]} + 16'(2 * (i % 2));
            cpu_u.access(b, 1'b0, 8'h00, rd);
            cpu_u.access(b + 16'h1, 1'b0, dir_tab[i], rd);
            check(pin_oe[i], dir_tab[i]);
            cpu_u.access(b, 1'b0, 8'h04, rd);
            cpu_u.access(b + 16'h1, 1'b0, 8'ha5, rd);
            check(pin_out[i] & dir_tab[i], 8'ha5 & dir_tab[i]);
            cpu_u.access(b + 16'h1, 1'b1, 8'h00, rd);
            check(rd, (dir_tab[i] & 8'ha5) | (~dir_tab[i] & pin_in[i]));
            cpu_u.access(b, 1'b1, 8'h00, rd);
            check(rd, 8'h04);
        end
    endtask : t_ports

    task automatic t_irq();
        cpu_u.access(16'h0418, 1'b0, 8'h07, rd);
        stb1[4] <= 1'b1;
        repeat (6) @(negedge clk);
        check(irq_n, 8'hef);
        cpu_u.access(16'h0418, 1'b1, 8'h00, rd);
        check(rd, 8'h87);
        cpu_u.access(16'h0419, 1'b1, 8'h00, rd);
        check(irq_n, 8'hff);
        cpu_u.access(16'h041a, 1'b0, 8'h05, rd);
        stb1[5] <= 1'b1;
        repeat (6) @(negedge clk);
        check(irq_n, 8'hff);
        stb1[5] <= 1'b0;
        repeat (6) @(negedge clk);
        check(irq_n, 8'hdf);
        cpu_u.access(16'h041b, 1'b1, 8'h00, rd);
        check(irq_n, 8'hff);
        cpu_u.access(16'h041a, 1'b0, 8'h1c, rd);
        stb2[5] <= 1'b1;
        repeat (6) @(negedge clk);
        check(irq_n, 8'hdf);
        cpu_u.access(16'h041a, 1'b1, 8'h00, rd);
        check(rd, 8'h5c);
        cpu_u.access(16'h041b, 1'b1, 8'h00, rd);
        check(irq_n, 8'hff);
        cpu_u.access(16'h041a, 1'b0, 8'h28, rd);
        check({s2o, s2oe, irq_n}, 24'h2020ff);
    endtask : t_irq

    initial begin
        do_reset(1'b0);
        t_ram();
        t_rom_map(1'b0);
        t_ports();
        t_irq();
        do_reset(1'b1);
        t_rom_map(1'b1);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule : mad_decoder_tb
`default_nettype wire
